// [hdl/sampler_pkg.sv]
/*
 * Shared constants and types for the sampler mode sequencer.
 * Assumes a 125 MHz system clock and an external seconds count from a real-time clock.
 */
`default_nettype none

package sampler_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 8;
	localparam int unsigned TICK_PERIOD_NS = 1_000_000_000;
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned DEV_LIMIT_S    = 60;
	localparam int unsigned OUTAGE_LIMIT_S = 60;
	localparam int unsigned DEV_PCT        = 10;

	// ------------------------------------------------------------
	// widths and flow defaults (units of 0.01 L/min)
	// ------------------------------------------------------------
	localparam int unsigned FLOW_W = 16;
	localparam int unsigned TIME_W = 32;
	localparam int unsigned SEC_W  = 8;
	localparam logic [15:0] FLOW_SINGLE_DEF = 16'h0683;
	localparam logic [15:0] FLOW_FINE_DEF   = 16'h05DC;
	localparam logic [15:0] FLOW_COARSE_DEF = 16'h00A7;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_STOP, ST_WAIT, ST_SAMPLING, ST_DONE, ST_FAULT, ST_AUDIT
	} mode_t;

	typedef struct packed {
		logic run;
		logic menu;
		logic audit;
		logic stop;
		logic confirm;
	} keys_t;

	typedef struct packed {
		logic flow_dev;
		logic outage;
	} status_t;

endpackage

`default_nettype wire

// [hdl/sampler_mode_sequencer.sv]
/*
 * Operating-mode sequencer of a filter air sampler: stop, wait, sampling, done, fault, audit.
 * Assumes keypad and power-fail lines are asynchronous pins; the real-time seconds count,
 * schedule times, flow readings and setpoint loads come from logic on MCLK.
 */
// Overview of operation
// - stop is the only idle mode; parameter edits are allowed only there
// - run key in stop goes to wait, or to sampling if start time reached
// - wait moves to sampling when the clock reaches the start time
// - sampling commands flow at setpoints, defaults 16.67, or 1.67 and 15 L/min
// - sampling ends on 10% flow deviation beyond 60 s, else at end time
// - sustained deviation stops sampling, enters fault, holds the deviation code
// - menu key while sampling offers audit or stop; chosen mode is entered
// - at end time enter done if status ok, otherwise fault
// - sample information edits are blocked while sampling
// - run key in done returns to stop
// - fault on end with bad status or on deviation; run key returns to stop
// - any return to stop from wait, sampling, done or fault finalizes the record
// - audit suspends operation; entry and exit each need a confirm key
// - outage over 60 s while sampling sets outage code and stores its start
// - after outage while sampling, resume before end time, else done or fault
// - outage outside sampling restores the pre-outage mode
// - the current mode is always shown on a status output
`default_nettype none

module sampler_mode_sequencer
	import sampler_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYCLES
) (
	input  wire logic                MCLK,
	input  wire logic                RST,
	input  wire keys_t               KEYS,
	input  wire logic                PWR_FAIL,
	input  wire logic                DUAL_UNIT,
	input  wire logic [TIME_W-1:0]   NOW,
	input  wire logic [TIME_W-1:0]   START_AT,
	input  wire logic [TIME_W-1:0]   END_AT,
	input  wire logic [FLOW_W-1:0]   FLOW_FINE,
	input  wire logic [FLOW_W-1:0]   FLOW_COARSE,
	input  wire logic                SETPT_LOAD,
	input  wire logic [FLOW_W-1:0]   SETPT_FINE,
	input  wire logic [FLOW_W-1:0]   SETPT_COARSE,
	output var  mode_t               MODE,
	output var  logic                PARAM_EDIT_EN,
	output var  logic                SAMPLE_EDIT_EN,
	output var  logic                PUMP_ON,
	output var  logic [FLOW_W-1:0]   FLOW_CMD_FINE,
	output var  logic [FLOW_W-1:0]   FLOW_CMD_COARSE,
	output var  status_t             STATUS,
	output var  logic                CHOICE_SHOWN,
	output var  logic                AUDIT_PEND,
	output var  logic                REC_FINAL,
	output var  logic                OUTAGE_WR,
	output var  logic [TIME_W-1:0]   OUTAGE_START
);

	// ------------------------------------------------------------
	// pin synchronisers and key edges
	// ------------------------------------------------------------
	keys_t       key_s1_ff, key_s2_ff, key_d_ff;
	logic [1:0]  pin_s1_ff, pin_s2_ff;
	logic        pwr_d_ff;
	keys_t       key_hit;
	logic        pwr_fail, dual, pwr_down, pwr_back;

	always_ff @(posedge MCLK) begin
		key_s1_ff <= KEYS;
		key_s2_ff <= key_s1_ff;
		pin_s1_ff <= {PWR_FAIL, DUAL_UNIT};
		pin_s2_ff <= pin_s1_ff;
		if (RST) begin
			key_d_ff <= '0;
			pwr_d_ff <= 1'b0;
		end else begin
			key_d_ff <= key_s2_ff;
			pwr_d_ff <= pin_s2_ff[1];
		end
	end

	assign key_hit  = key_s2_ff & ~key_d_ff;
	assign pwr_fail = pin_s2_ff[1];
	assign dual     = pin_s2_ff[0];
	assign pwr_down = pwr_fail & ~pwr_d_ff;
	assign pwr_back = ~pwr_fail & pwr_d_ff;

	// ------------------------------------------------------------
	// one-second tick
	// ------------------------------------------------------------
	logic [31:0] div_ff;
	logic        tick_ff;
	logic        div_end;

	assign div_end = (div_ff == 32'(TICK_DIV - 1));

	always_ff @(posedge MCLK) begin
		if (RST) begin
			div_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			div_ff  <= div_end ? '0 : div_ff + 32'h1;
			tick_ff <= div_end;
		end
	end

	// ------------------------------------------------------------
	// setpoints; user values load only in stop
	// ------------------------------------------------------------
	mode_t             mode_ff, nxt_mode;
	logic [FLOW_W-1:0] sp_fine_ff, sp_coarse_ff;
	logic              sp_user_ff;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			sp_fine_ff   <= FLOW_SINGLE_DEF;
			sp_coarse_ff <= FLOW_COARSE_DEF;
			sp_user_ff   <= 1'b0;
		end else if (mode_ff == ST_STOP && SETPT_LOAD) begin
			sp_fine_ff   <= SETPT_FINE;
			sp_coarse_ff <= SETPT_COARSE;
			sp_user_ff   <= 1'b1;
		end else if (!sp_user_ff) begin
			sp_fine_ff   <= dual ? FLOW_FINE_DEF : FLOW_SINGLE_DEF;
			sp_coarse_ff <= FLOW_COARSE_DEF;
		end
	end

	// ------------------------------------------------------------
	// flow deviation monitor
	// ------------------------------------------------------------
	logic [SEC_W-1:0] dev_cnt_ff;
	logic             dev_fine, dev_coarse, dev_any, dev_trip;

	function automatic logic off_tol(input logic [FLOW_W-1:0] meas, input logic [FLOW_W-1:0] sp);
		logic [FLOW_W-1:0] diff;
		diff = (meas >= sp) ? meas - sp : sp - meas;
		return ({7'h00, diff} * 23'd100) >= ({7'h00, sp} * 23'(DEV_PCT));
	endfunction

	assign dev_fine   = off_tol(FLOW_FINE, sp_fine_ff);
	assign dev_coarse = dual & off_tol(FLOW_COARSE, sp_coarse_ff);
	assign dev_any    = dev_fine | dev_coarse;
	assign dev_trip   = dev_cnt_ff > SEC_W'(DEV_LIMIT_S);

	always_ff @(posedge MCLK) begin
		if (RST || mode_ff != ST_SAMPLING || !dev_any) begin
			dev_cnt_ff <= '0;
		end else if (tick_ff && !pwr_fail && !dev_trip) begin
			dev_cnt_ff <= dev_cnt_ff + SEC_W'(1);
		end
	end

	// ------------------------------------------------------------
	// outage timing
	// ------------------------------------------------------------
	logic [SEC_W-1:0]  out_cnt_ff;
	logic [TIME_W-1:0] out_start_ff;
	logic              long_outage;

	assign long_outage = out_cnt_ff > SEC_W'(OUTAGE_LIMIT_S);

	always_ff @(posedge MCLK) begin
		if (RST) begin
			out_cnt_ff   <= '0;
			out_start_ff <= '0;
		end else if (pwr_down) begin
			out_cnt_ff   <= '0;
			out_start_ff <= NOW;
		end else if (pwr_fail && tick_ff && !long_outage) begin
			out_cnt_ff   <= out_cnt_ff + SEC_W'(1);
		end
	end

	// ------------------------------------------------------------
	// mode sequencer
	// ------------------------------------------------------------
	status_t status_ff, nxt_status;
	mode_t   resume_ff, nxt_resume;
	logic    choice_ff, nxt_choice;
	logic    apend_ff, nxt_apend;
	logic    started, ended, bad_status, out_hit;

	assign started    = NOW >= START_AT;
	assign ended      = NOW >= END_AT;
	assign bad_status = |status_ff;
	assign out_hit    = pwr_back && mode_ff == ST_SAMPLING && long_outage;

	always_comb begin
		nxt_mode   = mode_ff;
		nxt_status = status_ff;
		nxt_resume = resume_ff;
		nxt_choice = choice_ff;
		nxt_apend  = apend_ff;
		if (out_hit) begin
			nxt_status.outage = 1'b1;
		end
		if (pwr_fail) begin
			// mode, status and pending flags hold while power is down
			nxt_mode = mode_ff;
		end else if (apend_ff) begin
			if (key_hit.confirm) begin
				nxt_apend = 1'b0;
				if (mode_ff == ST_AUDIT) begin
					nxt_mode = resume_ff;
				end else begin
					nxt_resume = mode_ff;
					nxt_mode   = ST_AUDIT;
				end
			end else if (key_hit.stop) begin
				nxt_apend = 1'b0;
			end
		end else begin
			case (mode_ff)
				ST_STOP: begin
					if (key_hit.run) begin
						nxt_status = '0;
						nxt_mode   = started ? ST_SAMPLING : ST_WAIT;
					end else if (key_hit.audit) begin
						nxt_apend = 1'b1;
					end
				end
				ST_WAIT: begin
					if (started) begin
						nxt_mode = ST_SAMPLING;
					end else if (key_hit.stop) begin
						nxt_mode = ST_STOP;
					end else if (key_hit.audit) begin
						nxt_apend = 1'b1;
					end
				end
				ST_SAMPLING: begin
					if (dev_trip) begin
						nxt_status.flow_dev = 1'b1;
						nxt_mode            = ST_FAULT;
						nxt_choice          = 1'b0;
					end else if (ended) begin
						// outage code raised in this cycle counts as well
						nxt_mode   = (bad_status || out_hit) ? ST_FAULT : ST_DONE;
						nxt_choice = 1'b0;
					end else if (choice_ff && key_hit.stop) begin
						nxt_mode   = ST_STOP;
						nxt_choice = 1'b0;
					end else if (choice_ff && key_hit.audit) begin
						nxt_apend  = 1'b1;
						nxt_choice = 1'b0;
					end else if (key_hit.menu) begin
						nxt_choice = 1'b1;
					end
				end
				ST_DONE, ST_FAULT: begin
					if (key_hit.run) begin
						nxt_mode = ST_STOP;
					end else if (key_hit.audit) begin
						nxt_apend = 1'b1;
					end
				end
				ST_AUDIT: begin
					if (key_hit.audit) begin
						nxt_apend = 1'b1;
					end
				end
				default: nxt_mode = ST_STOP;
			endcase
		end
	end

	logic going_stop;
	logic pump_next;

	assign going_stop = nxt_mode == ST_STOP && mode_ff != ST_STOP && mode_ff != ST_AUDIT;
	assign pump_next  = nxt_mode == ST_SAMPLING && !pwr_fail;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			mode_ff   <= ST_STOP;
			status_ff <= '0;
			resume_ff <= ST_STOP;
			choice_ff <= 1'b0;
			apend_ff  <= 1'b0;
		end else begin
			mode_ff   <= nxt_mode;
			status_ff <= nxt_status;
			resume_ff <= nxt_resume;
			choice_ff <= nxt_choice;
			apend_ff  <= nxt_apend;
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (RST) begin
			MODE            <= ST_STOP;
			PARAM_EDIT_EN   <= 1'b1;
			SAMPLE_EDIT_EN  <= 1'b1;
			PUMP_ON         <= 1'b0;
			FLOW_CMD_FINE   <= '0;
			FLOW_CMD_COARSE <= '0;
			STATUS          <= '0;
			CHOICE_SHOWN    <= 1'b0;
			AUDIT_PEND      <= 1'b0;
			REC_FINAL       <= 1'b0;
			OUTAGE_WR       <= 1'b0;
			OUTAGE_START    <= '0;
		end else begin
			MODE            <= nxt_mode;
			PARAM_EDIT_EN   <= nxt_mode == ST_STOP;
			SAMPLE_EDIT_EN  <= nxt_mode != ST_SAMPLING;
			PUMP_ON         <= pump_next;
			FLOW_CMD_FINE   <= pump_next ? sp_fine_ff : '0;
			FLOW_CMD_COARSE <= (pump_next && dual) ? sp_coarse_ff : '0;
			STATUS          <= nxt_status;
			CHOICE_SHOWN    <= nxt_choice;
			AUDIT_PEND      <= nxt_apend;
			REC_FINAL       <= going_stop;
			OUTAGE_WR       <= out_hit;
			if (out_hit) begin
				OUTAGE_START <= out_start_ff;
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	sequence s_stop_run;
		mode_ff == ST_STOP && !pwr_fail && !apend_ff && key_hit.run;
	endsequence

	sequence s_trip;
		mode_ff == ST_SAMPLING && !pwr_fail && !apend_ff && dev_trip;
	endsequence

	a_edit_only_stop: assert property (PARAM_EDIT_EN |-> MODE == ST_STOP)
		else $error("parameter edit enabled outside stop");
	a_run_from_stop: assert property (s_stop_run |=> MODE == ($past(started) ? ST_SAMPLING : ST_WAIT))
		else $error("run key in stop gave wrong mode");
	a_wait_to_samp: assert property (mode_ff == ST_WAIT && !pwr_fail && !apend_ff && started |=> mode_ff == ST_SAMPLING)
		else $error("wait did not start sampling");
	a_flow_cmd_set: assert property (PUMP_ON |-> FLOW_CMD_FINE == $past(sp_fine_ff))
		else $error("fine flow command differs from setpoint");
	a_dev_fault: assert property (s_trip |=> mode_ff == ST_FAULT && status_ff.flow_dev ##1 status_ff.flow_dev)
		else $error("deviation did not fault and hold code");
	a_dev_count: assert property (dev_trip |-> $past(dev_any, 1))
		else $error("deviation tripped while flow in tolerance");
	a_end_outcome: assert property (mode_ff == ST_SAMPLING && !pwr_fail && !apend_ff && !dev_trip && ended |=> mode_ff == (($past(bad_status) || $past(out_hit)) ? ST_FAULT : ST_DONE))
		else $error("end of run gave wrong mode");
	a_no_samp_edit: assert property (MODE == ST_SAMPLING |-> !SAMPLE_EDIT_EN)
		else $error("sample edits open while sampling");
	a_done_to_stop: assert property (mode_ff inside {ST_DONE, ST_FAULT} && !pwr_fail && !apend_ff && key_hit.run |=> mode_ff == ST_STOP && REC_FINAL)
		else $error("run key did not return to stop with record");
	a_audit_confirm: assert property (mode_ff != ST_AUDIT ##1 mode_ff == ST_AUDIT |-> $past(key_hit.confirm) && $past(apend_ff))
		else $error("audit entered without confirm");
	a_outage_code: assert property (out_hit |=> status_ff.outage && OUTAGE_WR && OUTAGE_START == $past(out_start_ff))
		else $error("long outage not recorded");
	a_outage_hold: assert property (pwr_fail |=> mode_ff == $past(mode_ff))
		else $error("mode changed during outage");
	a_mode_shown: assert property (##1 MODE == $past(nxt_mode))
		else $error("mode indicator out of step");

endmodule // sampler_mode_sequencer

`default_nettype wire

// [bench/flow_plant_model.sv]
/*
 * Behavioural pump and flow sensor that sit behind the sequencer's flow commands.
 * Assumes the bench sets err_add to push the fine channel off its setpoint on purpose.
 */
`default_nettype none

module flow_plant_model
	import sampler_pkg::*;
(
	input  wire logic              pump_on,
	input  wire logic [FLOW_W-1:0] cmd_fine,
	input  wire logic [FLOW_W-1:0] cmd_coarse,
	input  wire logic [FLOW_W-1:0] err_add,
	output var  logic [FLOW_W-1:0] flow_fine,
	output var  logic [FLOW_W-1:0] flow_coarse
);
	timeunit 1ns;
	timeprecision 1ps;

	// a stopped pump moves no air, so readings drop to zero rather than hold
	assign flow_fine   = pump_on ? cmd_fine + err_add : '0;
	assign flow_coarse = pump_on ? cmd_coarse : '0;
endmodule // flow_plant_model

`default_nettype wire

// [bench/sampler_mode_sequencer_tb.sv]
/*
 * Self-checking bench for the sampler mode sequencer with a flow plant model.
 * Assumes the one-second tick is shortened to 10 clocks through TICK_DIV.
 */
`default_nettype none

module sampler_mode_sequencer_tb;
	import sampler_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam int unsigned DIV = 10;
	logic              MCLK, RST, PWR_FAIL, DUAL_UNIT, SETPT_LOAD;
	keys_t             KEYS;
	logic [TIME_W-1:0] NOW, START_AT, END_AT, OUTAGE_START, out_start;
	logic [FLOW_W-1:0] FLOW_FINE, FLOW_COARSE, SETPT_FINE, SETPT_COARSE;
	logic [FLOW_W-1:0] FLOW_CMD_FINE, FLOW_CMD_COARSE, err_add;
	mode_t             MODE;
	status_t           STATUS;
	logic              PARAM_EDIT_EN, SAMPLE_EDIT_EN, PUMP_ON, CHOICE_SHOWN;
	logic              AUDIT_PEND, REC_FINAL, OUTAGE_WR;
	int                fail_count, total_checks, rec_n, rec_exp, out_n, cycles;

	sampler_mode_sequencer #(.TICK_DIV(DIV)) i_dut (
		.MCLK(MCLK), .RST(RST), .KEYS(KEYS), .PWR_FAIL(PWR_FAIL), .DUAL_UNIT(DUAL_UNIT),
		.NOW(NOW), .START_AT(START_AT), .END_AT(END_AT), .FLOW_FINE(FLOW_FINE),
		.FLOW_COARSE(FLOW_COARSE), .SETPT_LOAD(SETPT_LOAD), .SETPT_FINE(SETPT_FINE),
		.SETPT_COARSE(SETPT_COARSE), .MODE(MODE), .PARAM_EDIT_EN(PARAM_EDIT_EN),
		.SAMPLE_EDIT_EN(SAMPLE_EDIT_EN), .PUMP_ON(PUMP_ON), .FLOW_CMD_FINE(FLOW_CMD_FINE),
		.FLOW_CMD_COARSE(FLOW_CMD_COARSE), .STATUS(STATUS), .CHOICE_SHOWN(CHOICE_SHOWN),
		.AUDIT_PEND(AUDIT_PEND), .REC_FINAL(REC_FINAL), .OUTAGE_WR(OUTAGE_WR),
		.OUTAGE_START(OUTAGE_START));

	flow_plant_model i_plant (
		.pump_on(PUMP_ON), .cmd_fine(FLOW_CMD_FINE), .cmd_coarse(FLOW_CMD_COARSE),
		.err_add(err_add), .flow_fine(FLOW_FINE), .flow_coarse(FLOW_COARSE));

	initial begin
		MCLK = 1'b0;
		forever #4 MCLK = ~MCLK;
	end

	// one-cycle pulses are counted here so scenarios need not race them
	always @(posedge MCLK) begin
		cycles++;
		if (REC_FINAL === 1'b1) rec_n++;
		if (OUTAGE_WR === 1'b1) begin
			out_n++;
			out_start = OUTAGE_START;
		end
		if (cycles == 12000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// key held 6 clocks covers the 3-edge answer, then low so the next press is an edge
	task automatic press(input keys_t k);
		@(negedge MCLK) KEYS = k;
		repeat (6) @(negedge MCLK);
		KEYS = '0;
		repeat (2) @(negedge MCLK);
	endtask

	task automatic wait_mode(input mode_t m, input int limit);
		int n;
		n = 0;
		while (MODE !== m && n < limit) begin
			@(negedge MCLK);
			n++;
		end
		chk("mode", MODE, m);
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge MCLK);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk("mode", MODE, ST_STOP);
		chk("param edit", PARAM_EDIT_EN, 1'b1);
		chk("pump", PUMP_ON, 1'b0);
	endtask

	task automatic t_schedule();
		press('{run: 1'b1, default: 1'b0});
		chk("mode", MODE, ST_WAIT);
		chk("param edit", PARAM_EDIT_EN, 1'b0);
		NOW = 10;
		wait_mode(ST_SAMPLING, 4);
		chk("pump", PUMP_ON, 1'b1);
		chk("fine cmd", FLOW_CMD_FINE, FLOW_SINGLE_DEF);
		chk("coarse cmd", FLOW_CMD_COARSE, 16'h0000);
		chk("sample edit", SAMPLE_EDIT_EN, 1'b0);
		NOW = 50;
		wait_mode(ST_DONE, 4);
		press('{run: 1'b1, default: 1'b0});
		rec_exp++;
		chk("mode", MODE, ST_STOP);
		chk("finals", rec_n, rec_exp);
	endtask

	task automatic t_choice_audit();
		DUAL_UNIT = 1'b1;
		NOW = 60;
		START_AT = 60;
		END_AT = 200;
		press('{run: 1'b1, default: 1'b0});
		chk("mode", MODE, ST_SAMPLING);
		chk("fine cmd", FLOW_CMD_FINE, FLOW_FINE_DEF);
		chk("coarse cmd", FLOW_CMD_COARSE, FLOW_COARSE_DEF);
		// a setpoint load outside stop must not reach the flow command
		SETPT_FINE = 16'h0123;
		SETPT_LOAD = 1'b1;
		idle(2);
		SETPT_LOAD = 1'b0;
		idle(2);
		chk("fine cmd", FLOW_CMD_FINE, FLOW_FINE_DEF);
		press('{menu: 1'b1, default: 1'b0});
		chk("choice", CHOICE_SHOWN, 1'b1);
		press('{audit: 1'b1, default: 1'b0});
		chk("audit pend", AUDIT_PEND, 1'b1);
		chk("mode", MODE, ST_SAMPLING);
		press('{confirm: 1'b1, default: 1'b0});
		chk("mode", MODE, ST_AUDIT);
		chk("pump", PUMP_ON, 1'b0);
		press('{audit: 1'b1, default: 1'b0});
		press('{confirm: 1'b1, default: 1'b0});
		chk("mode", MODE, ST_SAMPLING);
		press('{menu: 1'b1, default: 1'b0});
		press('{stop: 1'b1, default: 1'b0});
		rec_exp++;
		chk("mode", MODE, ST_STOP);
		chk("finals", rec_n, rec_exp);
	endtask

	task automatic t_outage_wait();
		START_AT = 500;
		press('{run: 1'b1, default: 1'b0});
		PWR_FAIL = 1'b1;
		idle(30);
		PWR_FAIL = 1'b0;
		idle(8);
		chk("mode", MODE, ST_WAIT);
		press('{stop: 1'b1, default: 1'b0});
		rec_exp++;
		chk("finals", rec_n, rec_exp);
	endtask

	task automatic t_deviation();
		SETPT_FINE = 16'h03E8;
		SETPT_COARSE = 16'h00C8;
		SETPT_LOAD = 1'b1;
		idle(2);
		SETPT_LOAD = 1'b0;
		START_AT = 60;
		END_AT = 1000;
		press('{run: 1'b1, default: 1'b0});
		chk("fine cmd", FLOW_CMD_FINE, 16'h03E8);
		chk("coarse cmd", FLOW_CMD_COARSE, 16'h00C8);
		// exactly 10 percent high counts as off setpoint
		err_add = 16'h0064;
		idle(40 * DIV);
		err_add = '0;
		idle(20);
		err_add = 16'h0064;
		idle(40 * DIV);
		chk("mode", MODE, ST_SAMPLING);
		wait_mode(ST_FAULT, 40 * DIV);
		chk("status", STATUS, 2'b10);
		chk("pump", PUMP_ON, 1'b0);
		err_add = '0;
		press('{run: 1'b1, default: 1'b0});
		rec_exp++;
		chk("mode", MODE, ST_STOP);
		chk("finals", rec_n, rec_exp);
	endtask

	task automatic t_outage_run();
		press('{run: 1'b1, default: 1'b0});
		chk("status", STATUS, 2'b00);
		NOW = 100;
		PWR_FAIL = 1'b1;
		idle(70 * DIV);
		chk("mode", MODE, ST_SAMPLING);
		chk("pump", PUMP_ON, 1'b0);
		PWR_FAIL = 1'b0;
		idle(10);
		chk("mode", MODE, ST_SAMPLING);
		chk("status", STATUS, 2'b01);
		chk("outage writes", out_n, 1);
		chk("outage start", out_start, 32'h0000_0064);
		NOW = 1000;
		wait_mode(ST_FAULT, 4);
		press('{run: 1'b1, default: 1'b0});
		rec_exp++;
		chk("finals", rec_n, rec_exp);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{fail_count, total_checks, rec_n, rec_exp, out_n, cycles} = '0;
		RST = 1'b1;
		KEYS = '0;
		{PWR_FAIL, DUAL_UNIT, SETPT_LOAD} = '0;
		{SETPT_FINE, SETPT_COARSE, err_add} = '0;
		NOW = 0;
		START_AT = 10;
		END_AT = 50;
		out_start = '0;
		repeat (16) @(negedge MCLK);
		RST = 1'b0;
		idle(2);
		t_reset();
		t_schedule();
		t_choice_audit();
		t_outage_wait();
		t_deviation();
		t_outage_run();
		tally_and_finish();
	end
endmodule // sampler_mode_sequencer_tb

`default_nettype wire
